// File: include/ssoe_pkg.sv
package ssoe_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SYS_CLK_MHZ     = 125;
  localparam int BIT_TIME_NS     = 1000;
  localparam int CYC_PER_BIT     = (BIT_TIME_NS * SYS_CLK_MHZ) / 1000;
  localparam int HALF_BIT_CYC    = CYC_PER_BIT / 2;
  localparam int BITS_PER_BYTE   = 8;

  localparam logic [6:0] HALF_BIT_LAST = 7'(HALF_BIT_CYC - 1);
  localparam logic [6:0] BIT_END_CYC   = 7'(CYC_PER_BIT - 1);
  localparam logic [3:0] BIT_LAST      = 4'(BITS_PER_BYTE - 1);

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic       SHIFT_CLK_IDLE = 1'b1;
  localparam logic       DATA_IDLE      = 1'b1;
  localparam logic [7:0] BYTE_RST       = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [7:0] data;
  } ssoe_word_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH
  } ssoe_state_t;

endpackage

// File: verilog/ssoe_buf2.sv
`timescale 1ns/100ps
module ssoe_buf2
  import ssoe_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            in_valid_in,
  input  ssoe_pkg::ssoe_word_t in_data_in,
  output logic                 in_ready_out,
  output logic                 out_valid_out,
  output ssoe_pkg::ssoe_word_t out_data_out,
  input  wire logic            out_ready_in
);
  // ==========================================================================
  // Two-entry buffer
  // ==========================================================================
  ssoe_word_t mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       next_wr_ptr;
  logic       next_rd_ptr;
  logic [1:0] next_count;
  logic       push;
  logic       pop;

  always_comb
  begin
    push        = in_valid_in && (count != 2'd2);
    pop         = out_ready_in && (count != 2'd0);
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop)
    begin
      next_count = count + 2'd1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'd1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  assign in_ready_out  = (count != 2'd2);
  assign out_valid_out = (count != 2'd0);
  assign out_data_out  = mem[rd_ptr];
endmodule

// File: verilog/ssoe_top.sv
// How it works
// - A byte written into the transmit buffer starts a serial send of that byte on the data pin.
// - Every byte send drives exactly eight pulses on the shift clock pin, one per bit.
// - Each bit takes one microsecond, so a byte takes eight microseconds.
// - Out of reset the port is already in shift-register mode and needs no setup.
`timescale 1ns/100ps
module ssoe_top
  import ssoe_pkg::*;
(
  input  wire logic       CLK_SYS_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic       WR_STROBE_IN,
  input  wire logic [7:0] WR_DATA_IN,
  output logic            WR_READY_OUT,
  output logic            BUSY_OUT,
  output logic            SER_DATA_OUT,
  output logic            SER_DATA_OE_OUT,
  output logic            SHIFT_CLK_OUT
);
  // ==========================================================================
  // Transmit buffer
  // ==========================================================================
  ssoe_word_t in_word;
  ssoe_word_t head_word;
  logic       buf_in_ready;
  logic       head_valid;
  logic       take;

  assign in_word.data = WR_DATA_IN;

  // A write while the buffer is full is not taken; software must watch ready
  ssoe_buf2 u_buf (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .in_valid_in   (WR_STROBE_IN),
    .in_data_in    (in_word),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (head_valid),
    .out_data_out  (head_word),
    .out_ready_in  (take)
  );

  // ==========================================================================
  // Shifter
  // ==========================================================================
  ssoe_state_t state;
  ssoe_state_t next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        ser_data;
  logic        next_ser_data;
  logic        ser_oe;
  logic        next_ser_oe;
  logic        sck;
  logic        next_sck;

  // ==========================================================================
  // Bit-rate divider
  // ==========================================================================
  // One count spans a whole bit; the low half takes the rounded-down share
  // of the odd cycle count, so a bit still lasts exactly one microsecond
  logic [6:0]  div_cnt;
  logic [6:0]  next_div_cnt;
  logic        rise_en;
  logic        fall_en;

  // One-cycle enables: rise ends the low half, fall ends the whole bit
  assign rise_en = (state == ST_LOW) && (div_cnt == HALF_BIT_LAST);
  assign fall_en = (state == ST_HIGH) && (div_cnt == BIT_END_CYC);

  always_comb
  begin
    next_div_cnt = div_cnt + 7'h01;
    // Held at zero while idle so every byte starts on a fresh bit
    if ((state == ST_IDLE) || fall_en)
    begin
      next_div_cnt = '0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      div_cnt <= '0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
    end
  end

  // ==========================================================================
  // Shift sequencer
  // ==========================================================================
  always_comb
  begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_ser_data = ser_data;
    next_ser_oe   = ser_oe;
    next_sck      = sck;
    take          = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_sck = SHIFT_CLK_IDLE;
        // Bit 0 leaves with the first falling edge, the rest wait in shreg
        if (head_valid)
        begin
          take          = 1'b1;
          next_shreg    = {1'b0, head_word.data[7:1]};
          next_ser_data = head_word.data[0];
          next_ser_oe   = 1'b1;
          next_sck      = 1'b0;
          next_bit_cnt  = '0;
          next_state    = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (rise_en)
        begin
          next_sck   = 1'b1;
          next_state = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (fall_en)
        begin
          // After the last high half the clock stays parked high
          if (bit_cnt == BIT_LAST)
          begin
            next_ser_data = DATA_IDLE;
            next_ser_oe   = 1'b0;
            next_state    = ST_IDLE;
          end
          else
          begin
            next_bit_cnt  = bit_cnt + 4'h1;
            next_ser_data = shreg[0];
            next_shreg    = {1'b0, shreg[7:1]};
            next_sck      = 1'b0;
            next_state    = ST_LOW;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state    <= ST_IDLE;
      bit_cnt  <= '0;
      shreg    <= BYTE_RST;
      ser_data <= DATA_IDLE;
      ser_oe   <= 1'b0;
      sck      <= SHIFT_CLK_IDLE;
    end
    else
    begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      ser_data <= next_ser_data;
      ser_oe   <= next_ser_oe;
      sck      <= next_sck;
    end
  end

  // ==========================================================================
  // Status
  // ==========================================================================
  logic        wr_ready;
  logic        next_wr_ready;
  logic        busy;
  logic        next_busy;

  always_comb
  begin
    // Ready trails the buffer by one cycle; a writer near full must space strobes
    next_wr_ready = buf_in_ready;
    next_busy     = head_valid || (next_state != ST_IDLE);
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      wr_ready <= 1'b0;
      busy     <= 1'b0;
    end
    else
    begin
      wr_ready <= next_wr_ready;
      busy     <= next_busy;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every pin comes straight from a register, so the far side sees no glitch
  assign WR_READY_OUT    = wr_ready;
  assign BUSY_OUT        = busy;
  assign SER_DATA_OUT    = ser_data;
  assign SER_DATA_OE_OUT = ser_oe;
  assign SHIFT_CLK_OUT   = sck;
endmodule

// File: tb/ssoe_far_sr.sv
`timescale 1ns/100ps
module ssoe_far_sr
(
  input  wire logic       sdat_in,
  input  wire logic       sclk_in,
  input  wire logic       latch_in,
  output logic      [7:0] q0_out,
  output logic      [7:0] q1_out
);
  logic [7:0] s0 = 8'h00;
  logic [7:0] s1 = 8'h00;
  // ==========================================
  // Two chained stages, outputs held until latch
  always @(posedge sclk_in)
  begin
    s0 <= {sdat_in, s0[7:1]};
    s1 <= {s0[0], s1[7:1]};
  end
  always @(posedge latch_in)
  begin
    q0_out <= s0;
    q1_out <= s1;
  end
endmodule

// File: tb/ssoe_top_assertions.sv
`timescale 1ns/100ps
module ssoe_top_assertions
(
  input wire logic       CLK_SYS_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       WR_STROBE_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic       WR_READY_OUT,
  input wire logic       BUSY_OUT,
  input wire logic       SER_DATA_OUT,
  input wire logic       SER_DATA_OE_OUT,
  input wire logic       SHIFT_CLK_OUT
);
  int cnt;
  int n;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================
  // Phase length and pulse count per byte
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      cnt <= 0;
      n <= 0;
    end
    else
    begin
      cnt <= $changed(SHIFT_CLK_OUT) ? 0 : cnt + 1;
      if ($rose(SHIFT_CLK_OUT))
        n <= n + 1;
      else if (SHIFT_CLK_OUT && cnt >= 62)
        n <= 0;
    end
  end
  property p_start;
    WR_STROBE_IN && WR_READY_OUT && !BUSY_OUT && !$past(WR_STROBE_IN) |->
      ##2 !SHIFT_CLK_OUT && SER_DATA_OE_OUT && SER_DATA_OUT == $past(WR_DATA_IN[0], 2);
  endproperty
  a_start: assert property (p_start) else $error("send did not start");
  property p_low;
    $rose(SHIFT_CLK_OUT) |-> cnt == 61;
  endproperty
  a_low: assert property (p_low) else $error("low phase length");
  property p_high;
    $fell(SHIFT_CLK_OUT) && n != 0 |-> cnt == 62;
  endproperty
  a_high: assert property (p_high) else $error("high phase length");
  property p_hold;
    $rose(SHIFT_CLK_OUT) |-> $stable(SER_DATA_OUT)[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("data moved near rise");
  property p_max;
    $rose(SHIFT_CLK_OUT) |-> n < 8;
  endproperty
  a_max: assert property (p_max) else $error("too many pulses");
  property p_end;
    SHIFT_CLK_OUT && cnt == 62 && n != 0 |-> n == 8;
  endproperty
  a_end: assert property (p_end) else $error("pulse count");
  property p_idle;
    !BUSY_OUT && !$past(BUSY_OUT) |-> SHIFT_CLK_OUT && !SER_DATA_OE_OUT && SER_DATA_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("idle lines wrong");
  c_byte: cover property (SHIFT_CLK_OUT && cnt == 62 && n == 8);
  c_full: cover property (!WR_READY_OUT && BUSY_OUT);
  c_b2b: cover property (WR_STROBE_IN && $past(WR_STROBE_IN));
endmodule
bind ssoe_top ssoe_top_assertions ssoe_top_assertions_inst (.CLK_SYS_IN, .SYS_RST_IN, .WR_STROBE_IN,
  .WR_DATA_IN, .WR_READY_OUT, .BUSY_OUT, .SER_DATA_OUT, .SER_DATA_OE_OUT, .SHIFT_CLK_OUT);

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import ssoe_pkg::*;
  logic       clk = 0;
  logic       rst = 1;
  logic       stb = 0;
  logic       lat = 0;
  logic [7:0] d   = 8'h00;
  logic       rdy, busy, sd, oe, sck, line;
  logic [7:0] q0, q1;
  int         errors = 0;
  int         cmp_count = 0;
  int         n;
  always #4 clk = ~clk;
  // Pull-up on the data line while released
  assign line = oe ? sd : 1'b1;
  ssoe_top ssoe_top_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .WR_STROBE_IN(stb), .WR_DATA_IN(d),
    .WR_READY_OUT(rdy), .BUSY_OUT(busy), .SER_DATA_OUT(sd), .SER_DATA_OE_OUT(oe), .SHIFT_CLK_OUT(sck));
  ssoe_far_sr ssoe_far_sr_inst (.sdat_in(line), .sclk_in(sck), .latch_in(lat), .q0_out(q0), .q1_out(q1));
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    for (int k = 0; k < 9 && !rdy; k++)
      @(posedge clk);
    stb <= 1;
    d <= v;
    @(posedge clk);
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic drain(output int c);
    c = 0;
    for (int k = 0; k < 5000 && (busy || k < 4); k++)
    begin
      @(posedge clk);
      c += (oe === 1'b1);
    end
    chk(16'h0000, {15'h0000, busy});
    lat <= 1;
    @(posedge clk);
    lat <= 0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    chk(16'h0001, {15'h0000, rdy});
    chk(16'h0001, {15'h0000, sck});
  endtask
  task automatic t_one;
    wr(8'hA5);
    drain(n);
    chk(16'h00A5, {8'h00, q0});
    chk(16'(BITS_PER_BYTE * CYC_PER_BIT), 16'(n));
  endtask
  task automatic t_b2b;
    stb <= 1;
    d <= 8'h3C;
    @(posedge clk);
    d <= 8'h81;
    @(posedge clk);
    stb <= 0;
    drain(n);
    chk(16'h003C, {8'h00, q1});
    chk(16'h0081, {8'h00, q0});
  endtask
  task automatic t_full;
    wr(8'h10);
    wr(8'h11);
    wr(8'h12);
    @(posedge clk);
    chk(16'h0000, {15'h0000, rdy});
    stb <= 1;
    d <= 8'hFF;
    @(posedge clk);
    stb <= 0;
    drain(n);
    chk(16'h1112, {q1, q0});
  endtask
  task automatic t_rst;
    wr(8'h5A);
    repeat (300) @(posedge clk);
    rst <= 1;
    repeat (8) @(posedge clk);
    chk(16'h0018, {11'h000, sck, sd, oe, busy, rdy});
    rst <= 0;
    repeat (2) @(posedge clk);
    chk(16'h0001, {15'h0000, rdy});
    wr(8'hC3);
    drain(n);
    chk(16'h00C3, {8'h00, q0});
    chk(16'(BITS_PER_BYTE * CYC_PER_BIT), 16'(n));
  endtask
  task automatic stop_test;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_reset;
    t_one;
    t_b2b;
    t_full;
    t_rst;
    stop_test;
  end
  initial
  begin
    #200000;
    errors++;
    stop_test;
  end
endmodule
